// >>> bench/cpsr_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_consts.svh"

// Port checker of the time-stamp and pulse block
module cpsr_checker #(
	parameter int SLOTS = 4
) (
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    rst,
	// Register port
	input wire logic [`CPSR_ADDR_W-1:0] regAddr,
	input wire logic [31:0]             regWrData,
	input wire logic                    regWrStb,
	input wire logic                    regRdStb,
	input wire logic [31:0]             regRdData,
	// Capture and pin
	input wire logic [SLOTS-1:0]        captureLoad,
	input wire logic                    capPinOut,
	input wire logic                    capPinOe
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_rd_idle;
		!$past(regRdStb) |-> regRdData == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");

	property p_unmapped;
		regRdStb && regAddr == 8'h20 |=> regRdData == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_phase_rw;
		regWrStb && regAddr == `CPSR_OFS_PHASE ##1 !regWrStb
			##1 regRdStb && regAddr == `CPSR_OFS_PHASE |=> regRdData == $past(regWrData, 3);
	endproperty
	a_phase_rw: assert property (p_phase_rw)
		else $error("phase readback wrong");

	property p_slot2_rw;
		!capPinOe && regWrStb && regAddr == 8'h0c && !captureLoad[1] ##1 !regWrStb
			&& !captureLoad[1] ##1 regRdStb && regAddr == 8'h0c |=> regRdData == $past(regWrData, 3);
	endproperty
	a_slot2_rw: assert property (p_slot2_rw)
		else $error("slot two readback wrong");

	property p_mirror;
		capPinOe && regWrStb && regAddr == 8'h08 ##1 !regWrStb
			##1 regRdStb && regAddr == 8'h10 |=> regRdData == $past(regWrData, 3);
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("active write missed its shadow");

	property p_oe_out;
		!capPinOe |-> !capPinOut;
	endproperty
	a_oe_out: assert property (p_oe_out)
		else $error("pin driven while released");

	property p_stat;
		regRdStb && regAddr == `CPSR_OFS_STATUS
			|=> regRdData[0] == $past(capPinOut) && regRdData[31:4] == 28'h0;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status word wrong");

	property p_ctrl_rsv;
		regRdStb && regAddr == `CPSR_OFS_CTRL |=> regRdData[31:5] == 27'h0 && !regRdData[3];
	endproperty
	a_ctrl_rsv: assert property (p_ctrl_rsv)
		else $error("control spare bits not zero");
endmodule

`default_nettype wire

// >>> bench/cpsr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Pin partner: an outside source drives the pin only while the block lets go of it
module cpsr_pin_model (
	// Block side
	input  wire logic capPinOut,
	input  wire logic capPinOe,
	// Outside source level
	input  wire logic extLevel,
	// Level seen on the pin
	output wire logic capPinIn
);
	// Two drivers on one pin would fight, so the enable picks one
	assign capPinIn = capPinOe ? capPinOut : extLevel;
endmodule

`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_consts.svh"

bind cpsr_top cpsr_checker #(.SLOTS(SLOTS)) chk (.core_clk(core_clk), .rst(rst),
	.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
	.regRdData(regRdData), .captureLoad(captureLoad), .capPinOut(capPinOut), .capPinOe(capPinOe));

module tb import cpsr_pkg::*;;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic       core_clk, rst, regWrStb, regRdStb, syncInEvent, extLevel;
	logic [7:0] regAddr;
	logic [3:0] captureLoad;
	cpsr_word_t regWrData, rdVal, firstVal;
	wire logic [31:0] regRdData;
	wire logic  capPinIn, capPinOut, capPinOe;
	int         n_errors = 0, checks = 0;

	cpsr_top dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.captureLoad(captureLoad), .syncInEvent(syncInEvent), .capPinIn(capPinIn),
		.capPinOut(capPinOut), .capPinOe(capPinOe));
	cpsr_pin_model pin (.capPinOut(capPinOut), .capPinOe(capPinOe), .extLevel(extLevel),
		.capPinIn(capPinIn));

	// 200 MHz clock
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ****************************************
	// Bus tasks and comparisons
	// ****************************************
	task automatic wr(input logic [7:0] a, input cpsr_word_t d);
		@(posedge core_clk);
		regWrStb  <= 1'h1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrStb  <= 1'h0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		regRdStb <= 1'h1;
		regAddr  <= a;
		@(posedge core_clk);
		regRdStb <= 1'h0;
		#1 rdVal = regRdData;
	endtask

	task automatic chk(input cpsr_word_t got, input cpsr_word_t exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input cpsr_word_t exp);
		rd(a);
		chk(rdVal, exp);
	endtask

	// Active cycles over ten periods of four, after the new compare settles
	task automatic duty(input logic pol, input int n);
		int act;
		act = 0;
		repeat (8) @(posedge core_clk);
		repeat (40) begin
			@(posedge core_clk);
			#1 act += (capPinOut === ~pol);
		end
		chk(32'(act), 32'(n * 10));
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		$display("[FAIL] %0t run limit reached", $time);
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'h1;
		regWrStb = 1'h0;
		regRdStb = 1'h0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		captureLoad = 4'h0;
		syncInEvent = 1'h0;
		extLevel = 1'h1;
		repeat (5) @(posedge core_clk);
		rst <= 1'h0;
		rchk(`CPSR_OFS_CTRL, 32'h0);
		rchk(`CPSR_OFS_COUNTER, 32'h0);
		wr(`CPSR_OFS_PHASE, 32'h1234abcd);
		rchk(`CPSR_OFS_PHASE, 32'h1234abcd);
		rchk(8'h20, 32'h0);
		$display("test registers done");
		// Captures with the counter held still, so the stamp is known
		wr(`CPSR_OFS_COUNTER, 32'h100);
		@(posedge core_clk);
		captureLoad <= 4'hf;
		@(posedge core_clk);
		captureLoad <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			rchk(8'h08 + 8'(4 * i), 32'h100);
		end
		wr(8'h0c, 32'h77);
		rchk(8'h0c, 32'h77);
		wr(`CPSR_OFS_CTRL, 32'h04);
		wr(8'h10, 32'h55);
		rchk(8'h08, 32'h100);
		rchk(8'h10, 32'h55);
		rchk(`CPSR_OFS_STATUS, 32'h6);
		chk(32'(capPinOe), 32'h0);
		$display("test capture done");
		// Sync event, software force, then free counting
		@(posedge core_clk);
		syncInEvent <= 1'h1;
		@(posedge core_clk);
		syncInEvent <= 1'h0;
		rchk(`CPSR_OFS_COUNTER, 32'h1234abcd);
		wr(`CPSR_OFS_COUNTER, 32'h0);
		wr(`CPSR_OFS_CTRL, 32'h0c);
		rchk(`CPSR_OFS_COUNTER, 32'h1234abcd);
		rchk(`CPSR_OFS_CTRL, 32'h04);
		wr(`CPSR_OFS_CTRL, 32'h10);
		rd(`CPSR_OFS_COUNTER);
		firstVal = rdVal;
		rd(`CPSR_OFS_COUNTER);
		chk(rdVal - firstVal, 32'h2);
		$display("test counter done");
		// Pulse mode, period of four cycles, every compare case in both polarities
		wr(`CPSR_OFS_CTRL, 32'h01);
		wr(8'h08, 32'h3);
		rchk(8'h10, 32'h3);
		wr(8'h0c, 32'h2);
		rchk(8'h14, 32'h2);
		wr(`CPSR_OFS_COUNTER, 32'h0);
		for (int p = 0; p < 2; p++) begin
			wr(`CPSR_OFS_CTRL, 32'h15 | (32'(p) << 1));
			for (int c = 0; c < 6; c++) begin
				wr(8'h14, (c == 5) ? 32'h9 : 32'(c));
				duty(p[0], (c > 4) ? 4 : c);
			end
		end
		chk(32'(capPinOe), 32'h1);
		$display("test pulse done");
		// Deferred load: nothing moves while the counter is held off the period
		wr(`CPSR_OFS_CTRL, 32'h01);
		wr(`CPSR_OFS_COUNTER, 32'h0);
		wr(8'h10, 32'h7);
		rchk(8'h08, 32'h3);
		wr(`CPSR_OFS_CTRL, 32'h11);
		repeat (10) @(posedge core_clk);
		rchk(8'h08, 32'h7);
		$display("test deferred done");
		finish_test();
	end
endmodule

`default_nettype wire

// >>> verilog/cpsr_cmp.sv
`timescale 1ns/1ps
`default_nettype none

// Full-width magnitude comparator, purely combinational
module cpsr_cmp #(
	parameter int W = 32
) (
	// Operands
	input  wire logic [W-1:0] lhs,
	input  wire logic [W-1:0] rhs,
	// Results
	output wire logic         isEqual,
	output wire logic         isLess
);

	// Both relations from one pair of operands
	assign isEqual = (lhs == rhs);
	assign isLess  = (lhs < rhs);

endmodule

`default_nettype wire

// >>> verilog/cpsr_consts.svh
`ifndef CPSR_CONSTS_SVH
`define CPSR_CONSTS_SVH

// ************************************************************
// Register map, byte addresses on the plain register port
// ************************************************************
`define CPSR_ADDR_W        8
`define CPSR_OFS_COUNTER   8'h00
`define CPSR_OFS_PHASE     8'h04
`define CPSR_OFS_SLOT1     8'h08
`define CPSR_SLOT_STEP     8'h04
`define CPSR_OFS_CTRL      8'h18
`define CPSR_OFS_STATUS    8'h1c

// ************************************************************
// Control word fields
// ************************************************************
`define CPSR_CTRL_MODE     0
`define CPSR_CTRL_POL      1
`define CPSR_CTRL_IMM      2
`define CPSR_CTRL_FORCE    3
`define CPSR_CTRL_RUN      4
`define CPSR_CTRL_W        5
`define CPSR_CTRL_RESET    5'h00

// ************************************************************
// Status word fields
// ************************************************************
`define CPSR_STAT_PIN_OUT  0
`define CPSR_STAT_PIN_IN   1
`define CPSR_STAT_PRD_EQ   2
`define CPSR_STAT_CMP_LT   3
`define CPSR_STAT_W        4

// ************************************************************
// Word values
// ************************************************************
`define CPSR_WORD_ZERO     32'h00000000
`define CPSR_WORD_ONE      32'h00000001

`endif

// >>> verilog/cpsr_pkg.sv
package cpsr_pkg;

	// Pin function select
	typedef enum logic {
		CPSR_MODE_CAPTURE = 1'b0,
		CPSR_MODE_PULSE   = 1'b1
	} cpsr_mode_e;

	// One time-stamp or compare word
	typedef logic [31:0] cpsr_word_t;

endpackage

// >>> verilog/cpsr_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "cpsr_consts.svh"

// Functional notes
// - capture mode blocks shadow-to-active transfers
// - immediate load copies shadow write at once
// - deferred load transfers on counter equals period
// - two separate full-width comparators in pulse mode
// - active write also fills its shadow
// - high polarity, compare zero: output low
// - high polarity, compare N: N high cycles
// - high polarity, compare=period: one low cycle
// - high polarity, compare>period: always high
// - low polarity, zero high; N low cycles
// - low polarity, period: one high cycle
// - running time-stamp counter readable as register
// - sync event or force loads phase offset
// - slot one: capture, write, active period
// - slot two: capture, write, active compare
// - slot three: capture or period shadow
// - slot four: capture or compare shadow
// - pin input in capture, output in pulse
// - counter counts up while run bit set, in either mode
// - polarity zero: compare gives high time
module cpsr_top
	import cpsr_pkg::*;
#(
	parameter int SLOTS = 4
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// Register port
	input  wire logic [`CPSR_ADDR_W-1:0]  regAddr,
	input  wire logic [31:0]              regWrData,
	input  wire logic                     regWrStb,
	input  wire logic                     regRdStb,
	output var  logic [31:0]              regRdData,
	// Capture events from the edge sequencer, one strobe per slot
	input  wire logic [SLOTS-1:0]         captureLoad,
	// Counter synchronisation
	input  wire logic                     syncInEvent,
	// Shared pin
	input  wire logic                     capPinIn,
	output var  logic                     capPinOut,
	output var  logic                     capPinOe
);

	// ************************************************************
	// Storage
	// ************************************************************

	cpsr_word_t             counter_r;
	cpsr_word_t             counter_nxt;
	cpsr_word_t             phase_r;
	cpsr_word_t             slot_r   [SLOTS];
	cpsr_word_t             slot_nxt [SLOTS];
	logic [`CPSR_CTRL_W-1:0] ctrl_r;
	logic                   pinOut_r;
	logic                   pinOe_r;
	logic                   pinIn_r;
	logic [31:0]            rdData_r;

	// ************************************************************
	// Control fields
	// ************************************************************

	cpsr_mode_e mode;
	logic       pulseMode;
	logic       polLow;
	logic       immLoad;
	logic       countRun;

	assign mode      = cpsr_mode_e'(ctrl_r[`CPSR_CTRL_MODE]);
	assign pulseMode = (mode == CPSR_MODE_PULSE);
	assign polLow    = ctrl_r[`CPSR_CTRL_POL];
	assign immLoad   = ctrl_r[`CPSR_CTRL_IMM];
	assign countRun  = ctrl_r[`CPSR_CTRL_RUN];

	// ************************************************************
	// Address decode
	// ************************************************************

	logic             hitCounter;
	logic             hitPhase;
	logic             hitCtrl;
	logic             hitStatus;
	logic [SLOTS-1:0] hitSlot;
	logic             hitSlotAny;
	logic             wrCounter;
	logic             wrPhase;
	logic             wrCtrl;
	logic [SLOTS-1:0] wrSlot;
	logic             forceSync;

	// Single-register decodes
	assign hitCounter = (regAddr == `CPSR_OFS_COUNTER);
	assign hitPhase   = (regAddr == `CPSR_OFS_PHASE);
	assign hitCtrl    = (regAddr == `CPSR_OFS_CTRL);
	assign hitStatus  = (regAddr == `CPSR_OFS_STATUS);
	assign hitSlotAny = |hitSlot;

	// Slots sit on consecutive words
	genvar gs;
	generate
		for (gs = 0; gs < SLOTS; gs++) begin : g_slotDecode
			assign hitSlot[gs] = (regAddr ==
				`CPSR_ADDR_W'(`CPSR_OFS_SLOT1 + gs * `CPSR_SLOT_STEP));
			assign wrSlot[gs]  = regWrStb && hitSlot[gs];
		end
	endgenerate

	// Write strobes per register
	assign wrCounter = regWrStb && hitCounter;
	assign wrPhase   = regWrStb && hitPhase;
	assign wrCtrl    = regWrStb && hitCtrl;

	// The force bit is an action, never stored, so it always reads zero
	assign forceSync = wrCtrl && regWrData[`CPSR_CTRL_FORCE];

	// ************************************************************
	// Comparators
	// ************************************************************

	logic periodEq;
	logic periodLt;
	logic cmpEq;
	logic cmpLt;

	// Counter against active period, used for wrap and deferred load
	cpsr_cmp #(
		.W (32)
	) u_periodCmp (
		.lhs     (counter_r),
		.rhs     (slot_r[0]),
		.isEqual (periodEq),
		.isLess  (periodLt)
	);

	// Counter against active compare, gives the active phase of the pulse
	cpsr_cmp #(
		.W (32)
	) u_compareCmp (
		.lhs     (counter_r),
		.rhs     (slot_r[1]),
		.isEqual (cmpEq),
		.isLess  (cmpLt)
	);

	// ************************************************************
	// Time-stamp counter
	// ************************************************************

	logic syncLoad;
	logic pulseWrap;
	logic deferLoad;

	assign syncLoad  = syncInEvent || forceSync;
	assign pulseWrap = pulseMode && periodEq;
	assign deferLoad = pulseMode && !immLoad && periodEq;

	// Sync has top priority so that phase alignment is never missed;
	// a stopped counter still takes phase and software loads
	always_comb begin
		if (syncLoad) begin
			counter_nxt = phase_r;
		end else if (wrCounter) begin
			counter_nxt = regWrData;
		end else if (!countRun) begin
			counter_nxt = counter_r;
		end else if (pulseWrap) begin
			counter_nxt = `CPSR_WORD_ZERO;
		end else begin
			counter_nxt = counter_r + `CPSR_WORD_ONE;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			counter_r <= `CPSR_WORD_ZERO;
		end else begin
			counter_r <= counter_nxt;
		end
	end

	// ************************************************************
	// Capture slots and shadow transfer
	// ************************************************************

	// Slots p and p+2 form an active/shadow pair in pulse mode:
	// slot one with slot three (period), slot two with slot four (compare).
	// In capture mode every slot is an independent time-stamp; a capture
	// strobe beats a software write in the same cycle so no event is lost.
	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			slot_nxt[i] = slot_r[i];
		end
		if (!pulseMode) begin
			for (int i = 0; i < SLOTS; i++) begin
				if (wrSlot[i]) begin
					slot_nxt[i] = regWrData;
				end
				if (captureLoad[i]) begin
					slot_nxt[i] = counter_r;
				end
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				// Deferred path at the period match
				if (deferLoad) begin
					slot_nxt[p] = slot_r[p + 2];
				end
				// Shadow write, copied straight through when loading is immediate
				if (wrSlot[p + 2]) begin
					slot_nxt[p + 2] = regWrData;
					if (immLoad) begin
						slot_nxt[p] = regWrData;
					end
				end
				// Active write lands in both halves of the pair
				if (wrSlot[p]) begin
					slot_nxt[p]     = regWrData;
					slot_nxt[p + 2] = regWrData;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				slot_r[i] <= `CPSR_WORD_ZERO;
			end
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				slot_r[i] <= slot_nxt[i];
			end
		end
	end

	// ************************************************************
	// Phase and control registers
	// ************************************************************

	logic [`CPSR_CTRL_W-1:0] ctrlWrVal;

	// Force is an action only; dropping it here keeps it reading zero
	// and stops a stored bit from looking like a pending sync
	always_comb begin
		ctrlWrVal                   = regWrData[`CPSR_CTRL_W-1:0];
		ctrlWrVal[`CPSR_CTRL_FORCE] = 1'b0;
	end

	// Software-only storage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_r <= `CPSR_WORD_ZERO;
			ctrl_r  <= `CPSR_CTRL_RESET;
		end else begin
			if (wrPhase) begin
				phase_r <= regWrData;
			end
			if (wrCtrl) begin
				ctrl_r <= ctrlWrVal;
			end
		end
	end

	// ************************************************************
	// Pulse output and pin direction
	// ************************************************************

	logic pulseActive;
	logic pinOutNxt;

	// Counter below compare is the active part of the period. Compare zero
	// is never active, compare N is active for counts 0..N-1, and any compare
	// above the period is active for the whole period.
	assign pulseActive = cmpLt;
	// Polarity zero drives the active part high, one drives it low
	assign pinOutNxt   = pulseMode && (pulseActive ^ polLow);

	// Registered so the pin never sees comparator glitches; this costs one
	// cycle of lag behind the counter but keeps every duty count exact
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinOut_r <= 1'b0;
			pinOe_r  <= 1'b0;
			pinIn_r  <= 1'b0;
		end else begin
			pinOut_r <= pinOutNxt;
			pinOe_r  <= pulseMode;
			pinIn_r  <= capPinIn;
		end
	end

	assign capPinOut = pinOut_r;
	assign capPinOe  = pinOe_r;

	// ************************************************************
	// Read path
	// ************************************************************

	logic [1:0]              slotIdx;
	logic [`CPSR_STAT_W-1:0] statusBits;
	logic [31:0]             ctrlWord;
	logic [31:0]             statusWord;
	logic [31:0]             rdMux;

	// One-hot slot hit to index
	always_comb begin
		slotIdx = 2'h0;
		for (int i = 0; i < SLOTS; i++) begin
			if (hitSlot[i]) begin
				slotIdx = 2'(i);
			end
		end
	end

	// Live view of the block's own state
	assign statusBits[`CPSR_STAT_PIN_OUT] = pinOut_r;
	assign statusBits[`CPSR_STAT_PIN_IN]  = pinIn_r;
	assign statusBits[`CPSR_STAT_PRD_EQ]  = periodEq;
	assign statusBits[`CPSR_STAT_CMP_LT]  = cmpLt;

	assign ctrlWord   = {{(32 - `CPSR_CTRL_W){1'b0}}, ctrl_r};
	assign statusWord = {{(32 - `CPSR_STAT_W){1'b0}}, statusBits};

	// Unmapped addresses read as zero
	assign rdMux = hitCounter ? counter_r :
		hitPhase   ? phase_r :
		hitSlotAny ? slot_r[slotIdx] :
		hitCtrl    ? ctrlWord :
		hitStatus  ? statusWord :
		`CPSR_WORD_ZERO;

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdData_r <= `CPSR_WORD_ZERO;
		end else if (regRdStb) begin
			rdData_r <= rdMux;
		end else begin
			rdData_r <= `CPSR_WORD_ZERO;
		end
	end

	assign regRdData = rdData_r;

endmodule

`default_nettype wire
